// [rtl/oft_iir_bank.sv]
// One bank's first-order IIR offset estimator.
// Assumes the caller only pulses upd with a legal shift and a sample of this bank.
`timescale 1ns/1ns
module oft_iir_bank import oft_pkg::*; #(
  parameter int SW   = 16,
  parameter int FRAC = 14
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  // Sample in
  input  wire logic                 upd,
  input  wire logic signed [SW-1:0] smp,
  input  wire logic [4:0]           shift,
  // Estimate out
  output logic signed [SW-1:0]      est_int
);

  typedef struct packed {
    logic signed [SW+FRAC-1:0] est;
  } oft_iir_s;

  oft_iir_s                 st_r;
  oft_iir_s                 st_nxt;
  logic signed [SW+FRAC:0]  diff;
  logic signed [SW+FRAC:0]  step;

  // ****************************************
  // Estimate update
  // ****************************************
  // Fraction bits keep the smallest step non-zero down to the narrowest coefficient
  always_comb begin
    st_nxt = st_r;
    diff   = $signed({smp[SW-1], smp, {FRAC{1'b0}}}) - $signed({st_r.est[SW+FRAC-1], st_r.est});
    step   = diff >>> shift;
    if (upd) begin
      st_nxt.est = st_r.est + step[SW+FRAC-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign est_int = st_r.est[SW+FRAC-1:FRAC];

  // ****************************************
  // Checks
  // ****************************************
  // A gap under one LSB can shift to a zero step, so only a two-LSB gap must move it
  property p_iir_rises;
    @(posedge sys_clk) disable iff (sys_rst)
    upd && ($signed({smp[SW-1], smp}) > $signed({est_int[SW-1], est_int}) + 2'sd1) && (shift <= 5'(FRAC))
      |=> st_r.est > $past(st_r.est);
  endproperty
  a_iir_rises: assert property (p_iir_rises) else $error("estimate did not move toward sample");

  property p_iir_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    !upd |=> st_r.est == $past(st_r.est);
  endproperty
  a_iir_hold: assert property (p_iir_hold) else $error("estimate moved without a sample");

endmodule // oft_iir_bank

// [rtl/oft_map.svh]
// Register map, field positions, reset values and filter constants for the offset trim filter.
// Assumes registers sit at their printed addresses on a 12-bit plain register port.
`ifndef OFT_MAP_SVH
`define OFT_MAP_SVH

// ****************************************
// Register addresses
// ****************************************
`define OFT_ADDR_TRIM   12'h094
`define OFT_ADDR_DCCTL  12'h097
`define OFT_ADDR_TUNE   12'h098
`define OFT_ADDR_CALCTL 12'h0A0
`define OFT_ADDR_STATUS 12'h0A1

// ****************************************
// Reset values
// ****************************************
`define OFT_TRIM_RSV_RST 4'h0
`define OFT_DCCTL_RST    8'h00
`define OFT_TUNE_RST     8'h33
`define OFT_CALCTL_RST   4'h0

// ****************************************
// Field positions
// ****************************************
`define OFT_TRIM_W       12
`define OFT_KEEPDC_BIT   0
`define OFT_BW_MSB       7
`define OFT_BW_LSB       4
`define OFT_SOAK_MSB     3
`define OFT_SOAK_LSB     0
`define OFT_OFFSET_CAL_ENABLE_BIT   0
`define OFT_BACKGROUND_CAL_ENABLE_BIT   1
`define OFT_BACKGROUND_OFFSET_CAL_ENABLE_BIT 2
`define OFT_CAL_FILT_BIT 3

// ****************************************
// Filter constants
// ****************************************
`define OFT_BW_MIN       4'h1
`define OFT_BW_MAX       4'h5
`define OFT_COEF_BASE    5'h09
`define OFT_SOAK_BASE    10

`endif

// [rtl/oft_pkg.sv]
// Types shared by the offset trim filter modules.
// Assumes oft_map.svh supplies the register widths.
package oft_pkg;

  // ****************************************
  // Soak sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    OFT_IDLE = 2'b01,
    OFT_SOAK = 2'b10
  } oft_soak_e;

  // ****************************************
  // Software visible storage
  // ****************************************
  typedef struct packed {
    logic [15:0] trim;
    logic [7:0]  dcctl;
    logic [7:0]  tune;
    logic [3:0]  calctl;
  } oft_regs_s;

endpackage

// [rtl/oft_trim_filter.sv]
// Offset trim, per-bank IIR offset filter and bank soak sequencer with its registers.
// Assumes samples, calibration flags and strobes come from logic on sys_clk; no synchronisers needed.
`timescale 1ns/1ns
`include "oft_map.svh"

// Behaviour
// - Add 12-bit trim on core2 second input
// - Trim resets to factory value, read/write
// - Keep-DC set: remove only bank mismatch
// - Keep-DC clear: remove full bank offset
// - Bandwidth code 1-5 selects coefficient
// - Soak field sets settle time after calibration
// - Soak only with filter and background enabled
// - Bank returns online when soak expires
module oft_trim_filter import oft_pkg::*; #(
  parameter int                     NUM_BANKS    = 6,
  parameter int                     SW           = 16,
  parameter int                     FRAC         = 14,
  parameter int                     SOAK_BASE    = `OFT_SOAK_BASE,
  parameter logic [`OFT_TRIM_W-1:0] TRIM_FACTORY = 12'h000
) (
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         sys_rst,
  // Register port
  input  wire logic [11:0]                  reg_addr,
  input  wire logic [15:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic [15:0]                       reg_rdata,
  // Calibration engine
  input  wire logic                         foreground_cal_done,
  input  wire logic                         cal_halted_flag,
  input  wire logic                         bank_cal_done,
  input  wire logic [$clog2(NUM_BANKS)-1:0] bank_cal_idx,
  output logic                              offset_cal_enable,
  output logic                              background_cal_enable,
  output logic                              background_offset_cal_enable,
  output logic                              offset_filter_enable,
  output logic [NUM_BANKS-1:0]              bank_online,
  // Sample stream in
  input  wire logic                         smp_valid,
  input  wire logic signed [SW-1:0]         smp_data,
  input  wire logic [$clog2(NUM_BANKS)-1:0] smp_bank,
  input  wire logic                         smp_core2_second_input,
  // Sample stream out
  output logic                              out_valid,
  output logic signed [SW-1:0]              out_data,
  output logic [$clog2(NUM_BANKS)-1:0]      out_bank
);

  localparam int BKW = $clog2(NUM_BANKS);
  localparam int CW  = SOAK_BASE + 16;

  typedef struct packed {
    oft_regs_s             regs;
    oft_soak_e             state;
    logic [BKW-1:0]        sbank;
    logic [CW-1:0]         cnt;
    logic [NUM_BANKS-1:0]  online;
    logic [15:0]           rdata;
    logic                  ovalid;
    logic signed [SW-1:0]  odata;
    logic [BKW-1:0]        obank;
  } oft_top_s;

  localparam oft_top_s RST_VAL = '{
    regs:   '{trim:   {`OFT_TRIM_RSV_RST, TRIM_FACTORY},
              dcctl:  `OFT_DCCTL_RST,
              tune:   `OFT_TUNE_RST,
              calctl: `OFT_CALCTL_RST},
    state:  OFT_IDLE,
    sbank:  '0,
    cnt:    '0,
    online: '1,
    rdata:  '0,
    ovalid: 1'b0,
    odata:  '0,
    obank:  '0
  };

  oft_top_s                   st_r;
  oft_top_s                   st_nxt;
  logic signed [SW-1:0]       est_int [NUM_BANKS];
  logic [NUM_BANKS-1:0]       upd;
  logic [3:0]                 bw;
  logic [3:0]                 soak;
  logic                       keep_dc;
  logic                       filt_on;
  logic                       soak_armed;
  logic [4:0]                 shift;
  logic signed [SW-1:0]       trim_add;
  logic signed [SW-1:0]       trimmed;
  logic signed [SW-1:0]       est_sel;
  logic signed [SW+7:0]       est_sum;
  logic signed [SW-1:0]       est_mean;
  logic signed [SW-1:0]       corr;

  // ****************************************
  // Decoders
  // ****************************************
  function automatic logic bw_ok(input logic [3:0] code);
    return (code >= `OFT_BW_MIN) && (code <= `OFT_BW_MAX);
  endfunction

  function automatic logic [CW-1:0] soak_len(input logic [3:0] code);
    return CW'(1) << (SOAK_BASE + int'(code));
  endfunction

  assign bw         = st_r.regs.tune[`OFT_BW_MSB:`OFT_BW_LSB];
  assign soak       = st_r.regs.tune[`OFT_SOAK_MSB:`OFT_SOAK_LSB];
  assign keep_dc    = st_r.regs.dcctl[`OFT_KEEPDC_BIT];
  // Reserved bandwidth codes bypass the filter rather than guess a coefficient
  assign filt_on    = offset_filter_enable && bw_ok(bw);
  assign soak_armed = offset_filter_enable && background_cal_enable;
  assign shift      = `OFT_COEF_BASE + {1'b0, bw};

  // ****************************************
  // Per-bank estimators
  // ****************************************
  generate
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      assign upd[b] = smp_valid && filt_on && (smp_bank == BKW'(b));
      oft_iir_bank #(
        .SW   (SW),
        .FRAC (FRAC)
      ) u_iir (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .upd     (upd[b]),
        .smp     (trimmed),
        .shift   (shift),
        .est_int (est_int[b])
      );
    end
  endgenerate

  // ****************************************
  // Datapath
  // ****************************************
  // Trim add wraps; the converter range leaves ample headroom in SW bits
  always_comb begin
    trim_add = smp_core2_second_input ? SW'(st_r.regs.trim[`OFT_TRIM_W-1:0]) : '0;
    trimmed  = smp_data + trim_add;
    est_sum  = '0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      est_sum = est_sum + (SW+8)'(est_int[i]);
    end
    est_mean = SW'(est_sum / NUM_BANKS);
    est_sel  = (smp_bank < BKW'(NUM_BANKS)) ? est_int[smp_bank] : '0;
    if (!filt_on) begin
      corr = '0;
    end else if (keep_dc) begin
      corr = est_sel - est_mean;
    end else begin
      corr = est_sel;
    end
  end

  // ****************************************
  // Registers, soak sequencer, output stage
  // ****************************************
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rdata  = '0;
    st_nxt.ovalid = smp_valid;
    if (smp_valid) begin
      st_nxt.odata = trimmed - corr;
      st_nxt.obank = smp_bank;
    end
    if (reg_wr) begin
      unique case (reg_addr)
        `OFT_ADDR_TRIM:   st_nxt.regs.trim   = reg_wdata;
        `OFT_ADDR_DCCTL:  st_nxt.regs.dcctl  = reg_wdata[7:0];
        `OFT_ADDR_TUNE:   st_nxt.regs.tune   = reg_wdata[7:0];
        `OFT_ADDR_CALCTL: st_nxt.regs.calctl = reg_wdata[3:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `OFT_ADDR_TRIM:   st_nxt.rdata = st_r.regs.trim;
        `OFT_ADDR_DCCTL:  st_nxt.rdata = {8'h00, st_r.regs.dcctl};
        `OFT_ADDR_TUNE:   st_nxt.rdata = {8'h00, st_r.regs.tune};
        `OFT_ADDR_CALCTL: st_nxt.rdata = {12'h000, st_r.regs.calctl};
        `OFT_ADDR_STATUS: st_nxt.rdata = {13'h0000, st_r.state == OFT_SOAK, cal_halted_flag, foreground_cal_done};
        default:          st_nxt.rdata = '0;
      endcase
    end
    unique case (st_r.state)
      OFT_IDLE: begin
        st_nxt.cnt = '0;
      end
      OFT_SOAK: begin
        if (!soak_armed) begin
          st_nxt.online[st_r.sbank] = 1'b1;
          st_nxt.state              = OFT_IDLE;
        end else if (st_r.cnt == CW'(1)) begin
          st_nxt.online[st_r.sbank] = 1'b1;
          st_nxt.state              = OFT_IDLE;
        end else begin
          st_nxt.cnt = st_r.cnt - CW'(1);
        end
      end
    endcase
    // A new calibrated bank pre-empts a soak in progress; the old bank goes back online
    if (bank_cal_done && (bank_cal_idx < BKW'(NUM_BANKS))) begin
      if (st_r.state == OFT_SOAK) begin
        st_nxt.online[st_r.sbank] = 1'b1;
      end
      if (soak_armed) begin
        st_nxt.state               = OFT_SOAK;
        st_nxt.sbank               = bank_cal_idx;
        st_nxt.cnt                 = soak_len(soak);
        st_nxt.online[bank_cal_idx] = 1'b0;
      end else begin
        st_nxt.state               = OFT_IDLE;
        st_nxt.online[bank_cal_idx] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= RST_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata                    = st_r.rdata;
  assign offset_cal_enable            = st_r.regs.calctl[`OFT_OFFSET_CAL_ENABLE_BIT];
  assign background_cal_enable        = st_r.regs.calctl[`OFT_BACKGROUND_CAL_ENABLE_BIT];
  assign background_offset_cal_enable = st_r.regs.calctl[`OFT_BACKGROUND_OFFSET_CAL_ENABLE_BIT];
  assign offset_filter_enable         = st_r.regs.calctl[`OFT_CAL_FILT_BIT];
  assign bank_online                  = st_r.online;
  assign out_valid                    = st_r.ovalid;
  assign out_data                     = st_r.odata;
  assign out_bank                     = st_r.obank;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_trim_reset;
    $fell(sys_rst) |-> st_r.regs.trim == {`OFT_TRIM_RSV_RST, TRIM_FACTORY};
  endproperty
  a_trim_reset: assert property (p_trim_reset) else $error("trim not at factory value after reset");

  property p_trim_readback;
    reg_wr && reg_addr == `OFT_ADDR_TRIM ##1 reg_rd && reg_addr == `OFT_ADDR_TRIM |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_trim_readback: assert property (p_trim_readback) else $error("trim read back wrong");

  property p_trim_add;
    smp_valid && !filt_on && smp_core2_second_input
      |=> out_data == $past(smp_data) + SW'($past(st_r.regs.trim[`OFT_TRIM_W-1:0]));
  endproperty
  a_trim_add: assert property (p_trim_add) else $error("trim not added on core2 second input");

  property p_trim_skip;
    smp_valid && !filt_on && !smp_core2_second_input |=> out_data == $past(smp_data);
  endproperty
  a_trim_skip: assert property (p_trim_skip) else $error("trim added on wrong input");

  property p_keep_dc;
    smp_valid && filt_on && keep_dc |=> out_data == $past(trimmed) - $past(est_sel) + $past(est_mean);
  endproperty
  a_keep_dc: assert property (p_keep_dc) else $error("keep-DC correction wrong");

  property p_strip_dc;
    smp_valid && filt_on && !keep_dc |=> out_data == $past(trimmed) - $past(est_sel);
  endproperty
  a_strip_dc: assert property (p_strip_dc) else $error("full offset not removed");

  property p_bw_reserved;
    smp_valid && !bw_ok(bw) |=> out_data == $past(trimmed) && upd == '0;
  endproperty
  a_bw_reserved: assert property (p_bw_reserved) else $error("reserved bandwidth code filtered");

  property p_soak_start;
    bank_cal_done && soak_armed && bank_cal_idx < BKW'(NUM_BANKS)
      |=> st_r.state == OFT_SOAK && st_r.cnt == soak_len($past(soak)) && !bank_online[$past(bank_cal_idx)];
  endproperty
  a_soak_start: assert property (p_soak_start) else $error("soak did not start");

  property p_soak_skip;
    bank_cal_done && !soak_armed && bank_cal_idx < BKW'(NUM_BANKS)
      |=> bank_online[$past(bank_cal_idx)] && st_r.state == OFT_IDLE;
  endproperty
  a_soak_skip: assert property (p_soak_skip) else $error("soak applied while disabled");

  property p_soak_end;
    st_r.state == OFT_SOAK && st_r.cnt == CW'(1) && soak_armed && !bank_cal_done
      |=> st_r.state == OFT_IDLE && bank_online[$past(st_r.sbank)];
  endproperty
  a_soak_end: assert property (p_soak_end) else $error("bank not online after soak");

endmodule // oft_trim_filter

// [tb/testbench.sv]
// Self-checking bench for the offset trim filter: registers, sample path, IIR model and bank soak.
// Assumes the design's register map header and a soak base shortened to 2 for simulation.
`timescale 1ns/1ns
`include "oft_map.svh"
module testbench;
  import oft_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic              sys_clk = 0;
  logic              sys_rst = 1;
  logic [11:0]       reg_addr = 0;
  logic [15:0]       reg_wdata = 0;
  logic              reg_wr = 0, reg_rd = 0;
  logic [15:0]       reg_rdata;
  logic              foreground_cal_done = 0, cal_halted_flag = 0, bank_cal_done = 0;
  logic [2:0]        bank_cal_idx = 0;
  logic              offset_cal_enable, background_cal_enable, background_offset_cal_enable, offset_filter_enable;
  logic [5:0]        bank_online;
  logic              smp_valid = 0, smp_core2_second_input = 0;
  logic signed [15:0] smp_data = 0;
  logic [2:0]        smp_bank = 0;
  logic              out_valid;
  logic signed [15:0] out_data;
  logic [2:0]        out_bank;
  int                miscompares = 0, checked = 0;
  // Bench model state: mirrors of software settings and per-bank estimates
  logic [11:0]       m_trim;
  logic [3:0]        m_bw;
  logic              m_keep, m_filt;
  longint            est [6];
  int                n;
  logic [3:0]        bw_list [8] = '{4'h1, 4'h2, 4'h0, 4'h3, 4'h4, 4'h6, 4'h5, 4'hF};

  always #50 sys_clk = ~sys_clk;

  oft_trim_filter #(.SOAK_BASE(2)) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .foreground_cal_done(foreground_cal_done), .cal_halted_flag(cal_halted_flag),
    .bank_cal_done(bank_cal_done), .bank_cal_idx(bank_cal_idx),
    .offset_cal_enable(offset_cal_enable), .background_cal_enable(background_cal_enable),
    .background_offset_cal_enable(background_offset_cal_enable),
    .offset_filter_enable(offset_filter_enable), .bank_online(bank_online),
    .smp_valid(smp_valid), .smp_data(smp_data), .smp_bank(smp_bank),
    .smp_core2_second_input(smp_core2_second_input),
    .out_valid(out_valid), .out_data(out_data), .out_bank(out_bank));

  // ****************************************
  // Compare and bus tasks
  // ****************************************
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1; reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 0;
    @(negedge sys_clk);
    chk16(nm, e, reg_rdata);
    @(negedge sys_clk);
    chk16({nm, "_idle"}, 16'h0000, reg_rdata);
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    sys_rst <= 1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 0;
    foreach (est[i]) est[i] = 0;
  endtask

  // ****************************************
  // Expected output of one sample
  // ****************************************
  function automatic logic [15:0] exp_out(input logic [15:0] d, input int b, input logic c2);
    logic [15:0] t;
    longint      ei [6];
    longint      mean;
    logic [15:0] r;
    t = d + (c2 ? {4'h0, m_trim} : 16'h0000);
    if (!(m_filt && m_bw >= 1 && m_bw <= 5)) return t;
    mean = 0;
    foreach (est[i]) begin
      ei[i] = est[i] >>> 14;
      mean += ei[i];
    end
    mean = mean / 6;
    r = m_keep ? t - 16'(ei[b] - mean) : t - 16'(ei[b]);
    est[b] = est[b] + ((((longint'($signed(t))) <<< 14) - est[b]) >>> (9 + m_bw));
    return r;
  endfunction

  task automatic send(input logic [15:0] d, input int b, input logic c2);
    logic [15:0] e;
    e = exp_out(d, b, c2);
    @(posedge sys_clk);
    smp_valid <= 1; smp_data <= d; smp_bank <= 3'(b); smp_core2_second_input <= c2;
    @(posedge sys_clk);
    smp_valid <= 0;
    @(negedge sys_clk);
    chk1("out_valid", 1'b1, out_valid);
    chk16("out_bank", 16'(b), {13'h0, out_bank});
    chk16("out_data", e, out_data);
    @(negedge sys_clk);
    chk1("out_valid_drop", 1'b0, out_valid);
    chk16("out_data_hold", e, out_data);
  endtask

  task automatic soak(input int idx, input logic [3:0] s, input logic exp_low);
    wr(`OFT_ADDR_TUNE, {8'h00, 4'h3, s});
    @(posedge sys_clk);
    bank_cal_done <= 1; bank_cal_idx <= 3'(idx);
    @(posedge sys_clk);
    bank_cal_done <= 0;
    n = 0;
    @(negedge sys_clk);
    while (bank_online[idx] === 1'b0 && n < 300) begin
      n++;
      @(negedge sys_clk);
    end
    chk16("soak_cycles", exp_low ? 16'(1 << (2 + s)) : 16'h0000, 16'(n));
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // Watchdog: whole run is under a thousand cycles
  // ****************************************
  initial begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    end_sim();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(39));
    m_trim = 12'h000; m_bw = 4'h3; m_keep = 0; m_filt = 0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 0;
    foreach (est[i]) est[i] = 0;
    // Reset values and unmapped places
    rdchk("trim", `OFT_ADDR_TRIM, 16'h0000);
    rdchk("dcctl", `OFT_ADDR_DCCTL, 16'h0000);
    rdchk("tune", `OFT_ADDR_TUNE, 16'h0033);
    rdchk("calctl", `OFT_ADDR_CALCTL, 16'h0000);
    wr(12'h096, 16'hFFFF);
    rdchk("unmapped", 12'h096, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      foreground_cal_done <= k[0]; cal_halted_flag <= k[1];
      rdchk("status", `OFT_ADDR_STATUS, {14'h0, 2'(k)});
    end
    // Trim written while no calibration runs, reserved bits stored
    foreground_cal_done <= 1;
    m_trim = 12'($urandom);
    // Write then read back with no gap between the strobes
    @(posedge sys_clk);
    reg_wr <= 1;
    reg_addr <= `OFT_ADDR_TRIM;
    reg_wdata <= {4'hA, m_trim};
    @(posedge sys_clk);
    reg_wr <= 0;
    reg_rd <= 1;
    @(posedge sys_clk);
    reg_rd <= 0;
    @(negedge sys_clk);
    chk16("trim", {4'hA, m_trim}, reg_rdata);
    wr(`OFT_ADDR_TRIM, {4'h5, 12'hFFF});
    m_trim = 12'hFFF;
    send(16'h7FFF, 2, 1);
    send(16'h7FFF, 2, 0);
    for (int k = 0; k < 20; k++) send(16'($urandom), $urandom % 6, 1'($urandom));
    // Calibration enables: each bit alone
    for (int k = 0; k < 4; k++) begin
      wr(`OFT_ADDR_CALCTL, 16'(1 << k));
      @(negedge sys_clk);
      chk16("enables", 16'(1 << k), {12'h0, offset_filter_enable, background_offset_cal_enable,
        background_cal_enable, offset_cal_enable});
    end
    // Filter on from clean estimates, every legal bandwidth code plus reserved codes 0, 6 and F
    do_reset();
    m_trim = 12'($urandom);
    wr(`OFT_ADDR_TRIM, {4'h0, m_trim});
    wr(`OFT_ADDR_CALCTL, 16'h0008);
    m_filt = 1;
    foreach (bw_list[j]) begin
      m_bw = bw_list[j];
      m_keep = j[0];
      wr(`OFT_ADDR_DCCTL, {15'h0, m_keep});
      wr(`OFT_ADDR_TUNE, {8'h00, m_bw, m_bw});
      for (int k = 0; k < 24; k++)
        send(16'(($urandom % 4096) + 16'h1000 * (k % 6)), k % 6, 1'($urandom));
    end
    // Soak: counts, no-effect cases, abort
    wr(`OFT_ADDR_CALCTL, 16'h000A);
    soak(1, 4'h0, 1);
    soak(5, 4'h2, 1);
    wr(`OFT_ADDR_CALCTL, 16'h0002);
    soak(3, 4'h1, 0);
    wr(`OFT_ADDR_CALCTL, 16'h0008);
    soak(0, 4'h1, 0);
    wr(`OFT_ADDR_CALCTL, 16'h000A);
    wr(`OFT_ADDR_TUNE, 16'h0033);
    @(posedge sys_clk);
    bank_cal_done <= 1; bank_cal_idx <= 3'd4;
    @(posedge sys_clk);
    bank_cal_done <= 0;
    @(negedge sys_clk);
    chk1("online_soak", 1'b0, bank_online[4]);
    rdchk("status_soak", `OFT_ADDR_STATUS, 16'h0007);
    wr(`OFT_ADDR_CALCTL, 16'h0008);
    repeat (2) @(negedge sys_clk);
    chk1("online_abort", 1'b1, bank_online[4]);
    end_sim();
  end
endmodule // testbench
